// >>> include/wwdt_pkg.sv
package wwdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing, times in their own unit
  localparam int CLK_PERIOD_NS = 4;
  localparam int WD_TIMEOUT_US = 1000;
  localparam int LATE_WINDOW_US = 1000;
  localparam int RESET_PERIOD_US = 200;
  // timeout and late limit are longest times: round down
  localparam int WD_TIMEOUT_CYC = (WD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int LATE_WINDOW_CYC = (LATE_WINDOW_US * 1000) / CLK_PERIOD_NS;
  // reset period is a least time: round up
  localparam int RESET_PERIOD_CYC =
    (RESET_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // early limit is the late limit shifted right, one shift per ratio select code 00, 01 and 11
  localparam logic [4:0] WIN_SHIFT_SEL0 = 5'h03;
  localparam logic [4:0] WIN_SHIFT_SEL1 = 5'h04;
  localparam logic [4:0] WIN_SHIFT_SEL3 = 5'h06;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;

  // control fields
  localparam int CTRL_WINDOWED_BIT = 0;
  localparam logic CTRL_WINDOWED_RST = 1'b1;

  // status and mask fields
  localparam int EVT_W = 4;
  localparam int EVT_EARLY_BIT = 0;
  localparam int EVT_LATE_BIT = 1;
  localparam int EVT_TIMEOUT_BIT = 2;
  localparam int EVT_RELEASE_BIT = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;

  // state register fields
  localparam int STATE_RSTN_BIT = 0;
  localparam int STATE_PRIM_BIT = 1;
  localparam int STATE_SEC_BIT = 2;
  localparam int STATE_FSM_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // supervisor states, gray along hold -> run <-> off
  typedef enum logic [1:0] {
    WWDT_HOLD = 2'b00,
    WWDT_RUN = 2'b01,
    WWDT_OFF = 2'b11
  } wwdt_state_t;

endpackage

// >>> logic/wwdt_sync.sv
`timescale 1ns/100ps
module wwdt_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pin side
  input wire logic pin_in,
  // core side
  output logic level_out,
  output logic edge_out
);

  logic meta_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic edge_q;
  logic agree;

  // a change counts only once the second and third stage agree
  assign agree = (s2_q == s3_q);

  // three stage chain; meta_q is read by s2_q only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
      edge_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      s2_q <= meta_q;
      s3_q <= s2_q;
      level_q <= agree ? s3_q : level_q;
      edge_q <= agree && (s3_q != level_q);
    end
  end

  assign level_out = level_q;
  assign edge_out = edge_q;

endmodule

// >>> logic/wwdt_top.sv
`timescale 1ns/100ps
// Overview of operation
// R1 - window selects pick ratio or switch off
// R2 - windowed: select a high, b low disables watchdog
// R3 - standard: kick edge before timeout, else reset
// R4 - standard counter clears on kick, held in reset
// R5 - windowed: too early or late kick resets
// R6 - windowed counter starts after reset released
// R7 - windowed counter clears on valid kick, reset
// R8 - keep-alive low holds primary output on
// R9 - primary off after enable low, keep-alive released
// R10 - secondary output follows its enable input
// R11 - off input low disables watchdog
// R12 - reset held full period after condition ends
// R13 - kick synchronised, both edges, timings parameterised
module wwdt_top
  import wwdt_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYC = 32'(WD_TIMEOUT_CYC),
  parameter logic [31:0] LATE_CYC = 32'(LATE_WINDOW_CYC),
  parameter logic [31:0] RESET_CYC = 32'(RESET_PERIOD_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watchdog pins
  input wire logic watchdog_kick_in,
  input wire logic window_select_a,
  input wire logic window_select_b,
  input wire logic watchdog_off_n,
  // supply monitor: output below its reset threshold
  input wire logic supply_low,
  // regulator control pins
  input wire logic primary_output_turn_on,
  input wire logic regulator_keep_alive_n,
  input wire logic secondary_output_turn_on,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rd_data,
  // outputs to the system
  output logic reset_out_n,
  output logic primary_regulator_output,
  output logic secondary_regulator_output,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins

  logic kick_edge;
  logic sel_a_s;
  logic sel_b_s;
  logic off_n_s;
  logic supply_low_s;
  logic prim_en_s;
  logic keep_n_s;
  logic sec_en_s;

  // kick pin, both edges reported as one pulse
  wwdt_sync #(.INIT(1'b0)) u_sync_kick ( // R13
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(watchdog_kick_in),
    .level_out(),
    .edge_out(kick_edge)
  );

  // window select straps
  wwdt_sync #(.INIT(1'b0)) u_sync_sel_a (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(window_select_a),
    .level_out(sel_a_s),
    .edge_out()
  );

  wwdt_sync #(.INIT(1'b0)) u_sync_sel_b (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(window_select_b),
    .level_out(sel_b_s),
    .edge_out()
  );

  // off input idles high so the watchdog is enabled out of reset
  wwdt_sync #(.INIT(1'b1)) u_sync_off (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(watchdog_off_n),
    .level_out(off_n_s),
    .edge_out()
  );

  // supply monitor; starts low-asserted so reset is held until it settles
  wwdt_sync #(.INIT(1'b1)) u_sync_supply (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(supply_low),
    .level_out(supply_low_s),
    .edge_out()
  );

  wwdt_sync #(.INIT(1'b0)) u_sync_prim (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(primary_output_turn_on),
    .level_out(prim_en_s),
    .edge_out()
  );

  wwdt_sync #(.INIT(1'b1)) u_sync_keep (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(regulator_keep_alive_n),
    .level_out(keep_n_s),
    .edge_out()
  );

  wwdt_sync #(.INIT(1'b0)) u_sync_sec (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in(secondary_output_turn_on),
    .level_out(sec_en_s),
    .edge_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers and next values

  wwdt_state_t state_q;
  wwdt_state_t state_d;
  logic [31:0] wd_cnt_q;
  logic [31:0] wd_cnt_d;
  logic [31:0] rst_cnt_q;
  logic [31:0] rst_cnt_d;
  logic windowed_q;
  logic windowed_d;
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] status_d;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] mask_d;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic reset_n_q;
  logic reset_n_d;
  logic prim_q;
  logic prim_d;
  logic sec_q;
  logic sec_d;
  logic irq_q;
  logic irq_d;

  ////////////////////////////////////////////////////////////////////////////
  // window limits and disable decode

  logic [4:0] win_shift;
  logic [31:0] early_lim;
  logic sel_disable;
  logic wd_disable;

  // code 10 is the off code, the other three pick a ratio
  assign sel_disable = sel_a_s & ~sel_b_s; // R2
  assign win_shift = ({sel_a_s, sel_b_s} == 2'b01) ? WIN_SHIFT_SEL1 :
                     ({sel_a_s, sel_b_s} == 2'b11) ? WIN_SHIFT_SEL3 :
                     WIN_SHIFT_SEL0; // R1
  assign early_lim = LATE_CYC >> win_shift; // R1
  // selects only matter in the windowed variant
  assign wd_disable = ~off_n_s | (windowed_q & sel_disable); // R11 R1

  ////////////////////////////////////////////////////////////////////////////
  // fault detection

  logic in_run;
  logic to_hit;
  logic late_hit;
  logic kick_early;
  logic kick_valid;
  logic fault_timeout;
  logic fault_late;
  logic fault_early;
  logic fault;

  assign in_run = (state_q == WWDT_RUN);
  assign to_hit = (wd_cnt_q >= (TIMEOUT_CYC - 32'h1));
  assign late_hit = (wd_cnt_q >= (LATE_CYC - 32'h1));
  assign kick_early = windowed_q & kick_edge & (wd_cnt_q < early_lim);
  // a kick in the last cycle still counts as in time
  assign fault_timeout = in_run & ~windowed_q & ~kick_edge & to_hit; // R3
  assign fault_late = in_run & windowed_q & ~kick_edge & late_hit; // R5
  assign fault_early = in_run & kick_early; // R5
  assign fault = fault_timeout | fault_late | fault_early;
  assign kick_valid = kick_edge & ~kick_early; // R7

  ////////////////////////////////////////////////////////////////////////////
  // supervisor state machine

  logic hold_done;

  assign hold_done = ~supply_low_s & (rst_cnt_q >= (RESET_CYC - 32'h1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      WWDT_HOLD: begin
        if (hold_done) begin // R12
          state_d = wd_disable ? WWDT_OFF : WWDT_RUN;
        end
      end
      WWDT_RUN: begin
        if (supply_low_s || fault) begin // R3 R5
          state_d = WWDT_HOLD;
        end else if (wd_disable) begin // R11 R2
          state_d = WWDT_OFF;
        end
      end
      WWDT_OFF: begin
        if (supply_low_s) begin
          state_d = WWDT_HOLD;
        end else if (!wd_disable) begin
          state_d = WWDT_RUN;
        end
      end
      default: begin
        state_d = WWDT_HOLD;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters

  // reset period restarts while the supply is still low
  assign rst_cnt_d = (state_q != WWDT_HOLD) ? 32'h0 :
                     supply_low_s ? 32'h0 :
                     hold_done ? rst_cnt_q :
                     rst_cnt_q + 32'h1; // R12

  // held at zero outside run, so counting begins only after release
  assign wd_cnt_d = !in_run ? 32'h0 : // R4 R6 R7 R11
                    kick_valid ? 32'h0 : // R4 R7
                    to_hit && !windowed_q ? wd_cnt_q :
                    late_hit && windowed_q ? wd_cnt_q :
                    wd_cnt_q + 32'h1;

  // reset output follows the state the machine is entering
  assign reset_n_d = (state_d != WWDT_HOLD); // R12

  ////////////////////////////////////////////////////////////////////////////
  // regulator enables

  // keep-alive can only extend an output already on, never start one
  assign prim_d = prim_en_s | (prim_q & ~keep_n_s); // R8 R9
  assign sec_d = sec_en_s; // R10

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  logic released;

  assign wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
  assign wr_status = reg_wr & (reg_addr == OFS_STATUS);
  assign wr_mask = reg_wr & (reg_addr == OFS_MASK);
  assign released = (state_q == WWDT_HOLD) & (state_d != WWDT_HOLD);

  assign evt_set = {released, fault_timeout, fault_late, fault_early};
  assign evt_clr = wr_status ? reg_wr_data[EVT_W-1:0] : 4'h0;
  // a new event wins over a write-one-to-clear in the same cycle
  assign status_d = (status_q & ~evt_clr) | evt_set;
  assign mask_d = wr_mask ? reg_wr_data[EVT_W-1:0] : mask_q;
  assign windowed_d = wr_ctrl ? reg_wr_data[CTRL_WINDOWED_BIT] : windowed_q;
  assign irq_d = |(status_d & mask_d);

  // read mux; unmapped offsets read as zero
  logic [DATA_W-1:0] rd_state;

  assign rd_state = {26'h0, state_q, 1'b0, sec_q, prim_q, reset_n_q};
  assign rd_data_d = !reg_rd ? 32'h0 :
                     (reg_addr == OFS_CTRL) ? {31'h0, windowed_q} :
                     (reg_addr == OFS_STATUS) ? {28'h0, status_q} :
                     (reg_addr == OFS_MASK) ? {28'h0, mask_q} :
                     (reg_addr == OFS_STATE) ? rd_state :
                     (reg_addr == OFS_COUNT) ? wd_cnt_q :
                     32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // state flops

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= WWDT_HOLD;
      wd_cnt_q <= 32'h0;
      rst_cnt_q <= 32'h0;
      reset_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wd_cnt_q <= wd_cnt_d;
      rst_cnt_q <= rst_cnt_d;
      reset_n_q <= reset_n_d;
    end
  end

  // software visible flops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      windowed_q <= CTRL_WINDOWED_RST;
      status_q <= STATUS_RST;
      mask_q <= MASK_RST;
      rd_data_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      windowed_q <= windowed_d;
      status_q <= status_d;
      mask_q <= mask_d;
      rd_data_q <= rd_data_d;
      irq_q <= irq_d;
    end
  end

  // regulator flops; both outputs start off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prim_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      prim_q <= prim_d;
      sec_q <= sec_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reset_out_n = reset_n_q;
  assign primary_regulator_output = prim_q;
  assign secondary_regulator_output = sec_q;
  assign irq = irq_q;
  assign reg_rd_data = rd_data_q;

endmodule

// >>> verification/windowed_watchdog_timer_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
  end \
end
module windowed_watchdog_timer_bench;
  import wwdt_pkg::*;
  localparam logic [31:0] TO = 32'h28;
  localparam logic [31:0] LT = 32'h40;
  localparam logic [31:0] RC = 32'h0a;
  logic core_clk, rst, kick, sel_a, sel_b, off_n, sup_low;
  logic en1, keep_n, en2, wr, rd, rst_n_out, prim, sec, irq, prim_m;
  logic [7:0] addr, per;
  logic [31:0] wdata, rdata, d;
  logic [3:0] e;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int tab[11][5];
  wwdt_top #(.TIMEOUT_CYC(TO), .LATE_CYC(LT), .RESET_CYC(RC)) dut_u (
    .core_clk(core_clk), .rst(rst), .watchdog_kick_in(kick),
    .window_select_a(sel_a), .window_select_b(sel_b),
    .watchdog_off_n(off_n), .supply_low(sup_low),
    .primary_output_turn_on(en1), .regulator_keep_alive_n(keep_n),
    .secondary_output_turn_on(en2), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rd_data(rdata),
    .reset_out_n(rst_n_out), .primary_regulator_output(prim),
    .secondary_regulator_output(sec), .irq(irq));
  wwdt_host host_u (.core_clk(core_clk), .period(per),
    .watchdog_kick_in(kick));
  //////////////////////////////////////////
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // register port: one-cycle strobes, read data in the next cycle only
  task automatic wr_reg(logic [7:0] a, logic [31:0] v);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    // data launched at the strobe edge, taken at the next edge
    @(posedge core_clk);
    v = rdata;
  endtask
  task automatic wait_hi();
    int n;
    n = 0;
    while (rst_n_out !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    // a reset that never lets go is a failure, not a silent skip
    if (n >= 100) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // expected sticky status after kicks every p cycles, 0 = no kicks
  function automatic logic [3:0] exp_st(int w, int a, int b, int o, int p);
    int sh;
    sh = (a && !b) ? -1 : (b ? (a ? int'(WIN_SHIFT_SEL3) :
      int'(WIN_SHIFT_SEL1)) : int'(WIN_SHIFT_SEL0));
    if (!o || (w && sh < 0)) return 4'h0;
    if (p == 0 || p >= int'(w ? LT : TO)) return w ? 4'ha : 4'hc;
    if (w && p < int'(LT >> sh)) return 4'h9;
    return 4'h0;
  endfunction
  //////////////////////////////////////////
  initial begin
    void'($urandom(32'h8849));
    {rst, sel_a, sel_b, sup_low, en1, en2, wr, rd} = 8'h80;
    {off_n, keep_n} = 2'b11;
    {addr, per, wdata, prim_m} = '0;
    // mode, select a, select b, off_n, kick period
    tab = '{'{0,0,0,1,20}, '{0,0,0,1,0}, '{0,1,0,1,50}, '{0,0,0,0,0},
      '{1,0,0,1,20}, '{1,0,0,1,5}, '{1,0,1,1,6}, '{1,0,1,1,3},
      '{1,1,1,1,3}, '{1,1,1,1,0}, '{1,1,0,1,0}};
    tick(16);
    rst <= 1'b0;
    wait_hi();
    rd_reg(OFS_CTRL, d);
    `CHK(d, 32'h1)
    rd_reg(OFS_STATUS, d);
    `CHK(d, 32'h8)
    rd_reg(8'h14, d);
    `CHK(d, 32'h0)
    wr_reg(OFS_STATE, 32'h0);
    rd_reg(OFS_STATE, d);
    `CHK(d, 32'h11)
    // each mode and select code, fast, valid, slow and absent kicks
    for (int i = 0; i < 11; i++) begin
      off_n <= 1'b0;
      per <= 8'h0;
      tick(8);
      wait_hi();
      wr_reg(OFS_CTRL, 32'(tab[i][0]));
      sel_a <= tab[i][1][0];
      sel_b <= tab[i][2][0];
      tick(8);
      wr_reg(OFS_STATUS, 32'hf);
      off_n <= tab[i][3][0];
      per <= 8'(tab[i][4]);
      tick(200);
      rd_reg(OFS_STATUS, d);
      e = exp_st(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
      `CHK(d, {28'h0, e})
      if (e == 4'h0) `CHK(rst_n_out, 1'b1)
    end
    // supply reset while counting; release event drives the interrupt
    per <= 8'd20;
    wr_reg(OFS_CTRL, 32'h0);
    wr_reg(OFS_MASK, 32'h8);
    rd_reg(OFS_MASK, d);
    `CHK(d, 32'h8)
    sup_low <= 1'b1;
    tick(12);
    rd_reg(OFS_COUNT, d);
    `CHK(d, 32'h0)
    `CHK(rst_n_out, 1'b0)
    sup_low <= 1'b0;
    wait_hi();
    tick(2);
    `CHK(irq, 1'b1)
    wr_reg(OFS_MASK, 32'h0);
    tick(2);
    `CHK(irq, 1'b0)
    wr_reg(OFS_MASK, 32'h8);
    tick(2);
    `CHK(irq, 1'b1)
    wr_reg(OFS_STATUS, 32'h8);
    tick(2);
    `CHK(irq, 1'b0)
    // random regulator enables and keep-alive
    for (int i = 0; i < 24; i++) begin
      en1 <= 1'($urandom);
      keep_n <= 1'($urandom);
      en2 <= 1'($urandom);
      tick(10);
      prim_m = en1 | (prim_m & ~keep_n);
      `CHK(prim, prim_m)
      `CHK(sec, en2)
    end
    report_and_stop();
  end
endmodule

// >>> verification/wwdt_host.sv
`timescale 1ns/100ps
module wwdt_host (
  // clock
  input wire logic core_clk,
  // toggle period in cycles, zero stops the host
  input wire logic [7:0] period,
  // kick pin, driven push-pull
  output logic watchdog_kick_in
);
  int cnt = 0;
  initial watchdog_kick_in = 1'b0;
  // a stopped host holds its level, so no edge reaches the device
  always @(posedge core_clk) begin
    if (period == 8'h00) begin
      cnt <= 0;
    end else if (cnt + 1 >= int'(period)) begin
      cnt <= 0;
      watchdog_kick_in <= ~watchdog_kick_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> verification/wwdt_top_asserts.sv
`timescale 1ns/100ps
module wwdt_top_asserts
  import wwdt_pkg::*;
#(
  parameter logic [31:0] TIMEOUT_CYC = 32'h28,
  parameter logic [31:0] LATE_CYC = 32'h40,
  parameter logic [31:0] RESET_CYC = 32'h0a
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins
  input wire logic watchdog_kick_in,
  input wire logic window_select_a,
  input wire logic window_select_b,
  input wire logic watchdog_off_n,
  input wire logic supply_low,
  input wire logic primary_output_turn_on,
  input wire logic regulator_keep_alive_n,
  input wire logic secondary_output_turn_on,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  // outputs
  input wire logic reset_out_n,
  input wire logic primary_regulator_output,
  input wire logic secondary_regulator_output
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic win_q;
  logic kick_q;
  logic [31:0] low_q;
  logic [31:0] idle_q;
  // any pause of supervision restarts the idle count
  wire logic sel_off = win_q & window_select_a & ~window_select_b;
  wire logic wd_stop = ~watchdog_off_n | sel_off | ~reset_out_n;
  wire logic kicked = watchdog_kick_in ^ kick_q;
  wire logic [31:0] limit = win_q ? LATE_CYC : TIMEOUT_CYC;
  // mode shadow; pin edges count before the sync delay, so bounds get slack
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      win_q <= CTRL_WINDOWED_RST;
      kick_q <= 1'b0;
      low_q <= '0;
      idle_q <= '0;
    end else begin
      if (reg_wr && reg_addr == OFS_CTRL) begin
        win_q <= reg_wr_data[CTRL_WINDOWED_BIT];
      end
      kick_q <= watchdog_kick_in;
      low_q <= reset_out_n ? '0 : low_q + 32'h1;
      idle_q <= (wd_stop | kicked) ? '0 : idle_q + 32'h1;
    end
  end
  //////////////////////////////////////////
  AST_FELL_RST: assert property ($fell(rst) |-> !reset_out_n)
    else $error("reset output high as reset releases");
  AST_HOLD_TIME: assert property (
    $rose(reset_out_n) |-> low_q >= RESET_CYC)
    else $error("reset output released too soon");
  AST_SUPPLY: assert property (supply_low [*7] |-> !reset_out_n)
    else $error("reset output high while supply low");
  AST_IDLE: assert property (idle_q <= limit + 32'h8)
    else $error("no fault after missing kick");
  AST_SEC_ON: assert property (
    secondary_output_turn_on [*7] |-> secondary_regulator_output)
    else $error("secondary output off while enabled");
  AST_SEC_OFF: assert property (
    !secondary_output_turn_on [*7] |-> !secondary_regulator_output)
    else $error("secondary output on while disabled");
  AST_KEEP: assert property (
    !regulator_keep_alive_n [*7] ##0 primary_regulator_output
    |=> primary_regulator_output)
    else $error("primary output dropped during keep-alive");
  AST_PRIM_OFF: assert property (
    (!primary_output_turn_on && regulator_keep_alive_n) [*8]
    |-> !primary_regulator_output)
    else $error("primary output still on");
  AST_WD_OFF: assert property (
    (!watchdog_off_n && !supply_low) [*8] ##0 reset_out_n |=> reset_out_n)
    else $error("fault while watchdog switched off");
  AST_SEL_OFF: assert property (
    (sel_off && !supply_low) [*8] ##0 reset_out_n |=> reset_out_n)
    else $error("fault while select code disables");
endmodule
bind wwdt_top wwdt_top_asserts #(
  .TIMEOUT_CYC(TIMEOUT_CYC),
  .LATE_CYC(LATE_CYC),
  .RESET_CYC(RESET_CYC)
) chk_u (
  .core_clk, .rst, .watchdog_kick_in, .window_select_a, .window_select_b,
  .watchdog_off_n, .supply_low, .primary_output_turn_on,
  .regulator_keep_alive_n, .secondary_output_turn_on, .reg_addr,
  .reg_wr_data, .reg_wr, .reset_out_n, .primary_regulator_output,
  .secondary_regulator_output
);
